// ==== hdl/acq_pkg.sv ====
// Constants and types for the acquisition block FIFO control
//------------------------------------------------------------
// Overview of operation
// - Mode bit picks single or continuous
// - Single mode stops after one block
// - Block size comes from length register
// - Single block done sets flag, goes idle
// - Continuous mode writes until FIFO full
// - Continuous full sets flag, goes idle
// - Continuous: occupancy reaching length flags block
// - Each sample read frees its location
// - Fast host reading keeps acquisition running
//------------------------------------------------------------
package acq_pkg;

    // Storage geometry
    localparam int SAMPLE_W = 16;
    localparam int DEPTH = 256;
    localparam int PTR_W = 8;
    localparam int COUNT_W = 9;

    // Register bus
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] LEN_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] MASK_OFFSET = 8'h0C;
    localparam logic [7:0] STATE_OFFSET = 8'h10;
    localparam logic [7:0] DATA_OFFSET = 8'h14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control fields
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam logic MODE_SINGLE = 1'h0;
    localparam logic MODE_CONT = 1'h1;
    localparam logic MODE_RESET = MODE_SINGLE;

    // Block length, in samples
    localparam logic [COUNT_W-1:0] LEN_MIN = 9'h001;
    localparam logic [COUNT_W-1:0] LEN_MAX = 9'h100;
    localparam logic [COUNT_W-1:0] LEN_RESET = 9'h100;

    // Status and mask layout
    localparam int FLAG_W = 2;
    localparam int FLAG_DONE = 0;
    localparam int FLAG_BLOCK = 1;
    localparam logic [FLAG_W-1:0] FLAG_RESET = 2'h0;

    // State register fields
    localparam int STATE_ACQ_BIT = 0;
    localparam int STATE_COUNT_LSB = 16;

    typedef enum logic [1:0] {
        idle_state = 2'b01,
        acquiring_state = 2'b10
    } acq_state_type;

    // Merge a bus write into a word under its byte strobes
    function automatic logic [31:0] apply_strb(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Keep a block length inside what the FIFO can hold
    function automatic logic [COUNT_W-1:0] clamp_len(input logic [31:0] v);
        logic [COUNT_W-1:0] res;
        if (v == 32'h0000_0000) begin
            res = LEN_MIN;
        end else if (v > 32'(LEN_MAX)) begin
            res = LEN_MAX;
        end else begin
            res = v[COUNT_W-1:0];
        end
        return res;
    endfunction

endpackage

// ==== hdl/sample_fifo.sv ====
// Sample FIFO held in flip-flops with occupancy count
`timescale 1ns/1ns
module sample_fifo
    import acq_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Write side
    input wire logic i_wr,
    input wire logic [SAMPLE_W-1:0] i_wr_data,
    // Read side
    input wire logic i_rd,
    output logic [SAMPLE_W-1:0] o_rd_data,
    // Fill state
    output logic [COUNT_W-1:0] o_count,
    output logic o_full,
    output logic o_empty
);

    logic [SAMPLE_W-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [COUNT_W-1:0] count;
    logic [PTR_W-1:0] next_wr_ptr;
    logic [PTR_W-1:0] next_rd_ptr;
    logic [COUNT_W-1:0] next_count;
    logic do_wr;
    logic do_rd;

    assign o_full = (count == COUNT_W'(DEPTH));
    assign o_empty = (count == '0);
    assign o_count = count;
    assign o_rd_data = mem[rd_ptr];

    always_comb begin
        do_wr = i_wr && !o_full;
        do_rd = i_rd && !o_empty;
        next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count;
        if (do_wr && !do_rd) begin
            next_count = count + 1'b1;
        end else if (do_rd && !do_wr) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // Storage has no reset; contents are only read once written
    always_ff @(posedge i_ref_clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= i_wr_data;
        end
    end

endmodule

// ==== hdl/flag_irq.sv ====
// Sticky status flags, interrupt mask and interrupt output
`timescale 1ns/1ns
module flag_irq
    import acq_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Events and software access
    input wire logic [FLAG_W-1:0] i_set,
    input wire logic [FLAG_W-1:0] i_clear,
    input wire logic i_mask_we,
    input wire logic [FLAG_W-1:0] i_mask_data,
    // State
    output logic [FLAG_W-1:0] o_status,
    output logic [FLAG_W-1:0] o_mask,
    output logic o_irq
);

    logic [FLAG_W-1:0] status;
    logic [FLAG_W-1:0] mask;
    logic irq;
    logic [FLAG_W-1:0] next_status;
    logic [FLAG_W-1:0] next_mask;
    logic next_irq;

    always_comb begin
        // Set beats clear so a same-cycle event is kept
        next_status = (status & ~i_clear) | i_set;
        next_mask = i_mask_we ? i_mask_data : mask;
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status <= FLAG_RESET;
            mask <= FLAG_RESET;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            mask <= next_mask;
            irq <= next_irq;
        end
    end

    assign o_status = status;
    assign o_mask = mask;
    assign o_irq = irq;

endmodule

// ==== hdl/acq_fifo_ctrl.sv ====
// Acquisition control: mode, block capture, AXI4-Lite register slave
`timescale 1ns/1ns
module acq_fifo_ctrl
    import acq_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Sample stream from the converter path
    input wire logic i_sample_valid,
    input wire logic [SAMPLE_W-1:0] i_sample_data,
    // AXI4-Lite write address
    input wire logic i_axi_awvalid,
    output logic o_axi_awready,
    input wire logic [ADDR_W-1:0] i_axi_awaddr,
    input wire logic [2:0] i_axi_awprot,
    // AXI4-Lite write data
    input wire logic i_axi_wvalid,
    output logic o_axi_wready,
    input wire logic [31:0] i_axi_wdata,
    input wire logic [3:0] i_axi_wstrb,
    // AXI4-Lite write response
    output logic o_axi_bvalid,
    input wire logic i_axi_bready,
    output logic [1:0] o_axi_bresp,
    // AXI4-Lite read address
    input wire logic i_axi_arvalid,
    output logic o_axi_arready,
    input wire logic [ADDR_W-1:0] i_axi_araddr,
    input wire logic [2:0] i_axi_arprot,
    // AXI4-Lite read data
    output logic o_axi_rvalid,
    input wire logic i_axi_rready,
    output logic [31:0] o_axi_rdata,
    output logic [1:0] o_axi_rresp,
    // Status to the system
    output logic o_irq,
    output logic o_acquiring
);

    //--------------------------------------------------------
    // Declarations
    //--------------------------------------------------------
    acq_state_type state;
    acq_state_type next_state;
    logic mode;
    logic next_mode;
    logic [COUNT_W-1:0] block_len;
    logic [COUNT_W-1:0] next_block_len;
    logic [COUNT_W-1:0] captured;
    logic [COUNT_W-1:0] next_captured;
    logic acquiring;
    logic next_acquiring;

    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_aw_held;
    logic next_w_held;
    logic [ADDR_W-1:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;

    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    logic do_write;
    logic wr_ctrl;
    logic wr_len;
    logic wr_status;
    logic wr_mask;
    logic rd_take;
    logic [31:0] ctrl_word;
    logic [31:0] len_word;
    logic start_req;
    logic [FLAG_W-1:0] flag_set;
    logic [FLAG_W-1:0] flag_clear;
    logic [FLAG_W-1:0] status;
    logic [FLAG_W-1:0] mask;

    logic fifo_wr;
    logic fifo_rd;
    logic [SAMPLE_W-1:0] fifo_rd_data;
    logic [COUNT_W-1:0] fifo_count;
    logic fifo_full;
    logic fifo_empty;

    //--------------------------------------------------------
    // Submodules
    //--------------------------------------------------------
    sample_fifo u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_wr(fifo_wr),
        .i_wr_data(i_sample_data),
        .i_rd(fifo_rd),
        .o_rd_data(fifo_rd_data),
        .o_count(fifo_count),
        .o_full(fifo_full),
        .o_empty(fifo_empty)
    );

    flag_irq u_flags (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_set(flag_set),
        .i_clear(flag_clear),
        .i_mask_we(wr_mask),
        .i_mask_data(next_mask_bits(w_data, w_strb)),
        .o_status(status),
        .o_mask(mask),
        .o_irq(o_irq)
    );

    // Mask written under the low byte strobe only
    function automatic logic [FLAG_W-1:0] next_mask_bits(
        input logic [31:0] d, input logic [3:0] s);
        logic [31:0] merged;
        merged = apply_strb({{(32-FLAG_W){1'b0}}, mask}, d, s);
        return merged[FLAG_W-1:0];
    endfunction

    //--------------------------------------------------------
    // Register write decode
    //--------------------------------------------------------
    always_comb begin
        do_write = aw_held && w_held && !bvalid;
        wr_ctrl = do_write && (aw_addr == CTRL_OFFSET);
        wr_len = do_write && (aw_addr == LEN_OFFSET);
        wr_status = do_write && (aw_addr == STATUS_OFFSET);
        wr_mask = do_write && (aw_addr == MASK_OFFSET);
        ctrl_word = apply_strb({31'h0000_0000, mode}, w_data, w_strb);
        len_word = apply_strb({23'h00_0000, block_len}, w_data, w_strb);
        start_req = wr_ctrl && ctrl_word[CTRL_START_BIT];
        // Writing a one clears that flag
        flag_clear = '0;
        if (wr_status && w_strb[0]) begin
            flag_clear = w_data[FLAG_W-1:0];
        end
        rd_take = i_axi_arvalid && arready;
        fifo_rd = rd_take && (i_axi_araddr == DATA_OFFSET) && !fifo_empty;
    end

    //--------------------------------------------------------
    // Acquisition state machine
    //--------------------------------------------------------
    always_comb begin
        next_state = state;
        next_mode = mode;
        next_block_len = block_len;
        next_captured = captured;
        fifo_wr = 1'b0;
        flag_set = '0;
        if (wr_ctrl) begin
            next_mode = ctrl_word[CTRL_MODE_BIT];
        end
        if (wr_len) begin
            next_block_len = clamp_len(len_word);
        end
        unique case (state)
            idle_state: begin
                // A start while acquiring is ignored
                if (start_req) begin
                    next_state = acquiring_state;
                    next_captured = '0;
                end
            end
            acquiring_state: begin
                if (mode == MODE_SINGLE) begin
                    // Samples offered while the FIFO is full are lost
                    fifo_wr = i_sample_valid && !fifo_full &&
                              (captured < block_len);
                    if (fifo_wr) begin
                        next_captured = captured + 1'b1;
                    end
                    if (next_captured >= block_len) begin
                        next_state = idle_state;
                        flag_set[FLAG_DONE] = 1'b1;
                    end
                end else begin
                    fifo_wr = i_sample_valid && !fifo_full;
                    if (fifo_full) begin
                        next_state = idle_state;
                        flag_set[FLAG_DONE] = 1'b1;
                    end
                    if (fifo_count >= block_len) begin
                        flag_set[FLAG_BLOCK] = 1'b1;
                    end
                end
            end
        endcase
        next_acquiring = (next_state == acquiring_state);
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= idle_state;
            mode <= MODE_RESET;
            block_len <= LEN_RESET;
            captured <= '0;
            acquiring <= 1'b0;
        end else begin
            state <= next_state;
            mode <= next_mode;
            block_len <= next_block_len;
            captured <= next_captured;
            acquiring <= next_acquiring;
        end
    end

    //--------------------------------------------------------
    // AXI4-Lite write channels
    //--------------------------------------------------------
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (i_axi_awvalid && awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = i_axi_awaddr;
        end
        if (i_axi_wvalid && wready) begin
            next_w_held = 1'b1;
            next_w_data = i_axi_wdata;
            next_w_strb = i_axi_wstrb;
        end
        if (bvalid && i_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (wr_ctrl || wr_len || wr_status || wr_mask) ?
                         RESP_OKAY : RESP_SLVERR;
        end
        // One write in flight: no new address or data until answered
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
        end
    end

    //--------------------------------------------------------
    // AXI4-Lite read channels
    //--------------------------------------------------------
    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && i_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (rd_take) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = 32'h0000_0000;
            unique case (i_axi_araddr)
                CTRL_OFFSET: next_rdata[CTRL_MODE_BIT] = mode;
                LEN_OFFSET: next_rdata[COUNT_W-1:0] = block_len;
                STATUS_OFFSET: next_rdata[FLAG_W-1:0] = status;
                MASK_OFFSET: next_rdata[FLAG_W-1:0] = mask;
                STATE_OFFSET: begin
                    next_rdata[STATE_ACQ_BIT] = acquiring;
                    next_rdata[STATE_COUNT_LSB +: COUNT_W] = fifo_count;
                end
                // Reading an empty FIFO returns zero and pops nothing
                DATA_OFFSET: begin
                    if (!fifo_empty) begin
                        next_rdata[SAMPLE_W-1:0] = fifo_rd_data;
                    end
                end
                default: next_rresp = RESP_SLVERR;
            endcase
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else begin
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    //--------------------------------------------------------
    // Outputs
    //--------------------------------------------------------
    assign o_axi_awready = awready;
    assign o_axi_wready = wready;
    assign o_axi_bvalid = bvalid;
    assign o_axi_bresp = bresp;
    assign o_axi_arready = arready;
    assign o_axi_rvalid = rvalid;
    assign o_axi_rdata = rdata;
    assign o_axi_rresp = rresp;
    assign o_acquiring = acquiring;

endmodule

// ==== sim/sample_source.sv ====
// Converter-side sample source model for the acquisition bench
`timescale 1ns/1ns
module sample_source (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Pacing
    input wire logic i_en,
    input wire logic [3:0] i_period,
    // Sample stream
    output logic o_valid,
    output logic [15:0] o_data
);
    logic [3:0] tick;
    logic [15:0] cnt;

    // One sample every i_period cycles; slow pacing lets a host keep up
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick <= 4'h0;
            cnt <= 16'h0000;
            o_valid <= 1'b0;
            o_data <= 16'h0000;
        end else if (i_en && tick == 4'h0) begin
            o_valid <= 1'b1;
            cnt <= cnt + 16'h0001;
            o_data <= cnt + 16'h0001;
            tick <= i_period - 4'h1;
        end else begin
            o_valid <= 1'b0;
            // Idle data inverts every cycle, so it never holds the previous cycle's value
            o_data <= ~o_data;
            if (tick != 4'h0) begin
                tick <= tick - 4'h1;
            end
            if (!i_en) begin
                cnt <= 16'h0000;
            end
        end
    end
endmodule

// ==== sim/acq_fifo_ctrl_checker.sv ====
// Concurrent checks on the acquisition control ports
`timescale 1ns/1ns
module acq_fifo_ctrl_checker
    import acq_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Register bus
    input wire logic i_axi_awvalid,
    input wire logic o_axi_awready,
    input wire logic [ADDR_W-1:0] i_axi_awaddr,
    input wire logic i_axi_wvalid,
    input wire logic o_axi_wready,
    input wire logic [31:0] i_axi_wdata,
    input wire logic [3:0] i_axi_wstrb,
    input wire logic o_axi_bvalid,
    input wire logic i_axi_bready,
    input wire logic [1:0] o_axi_bresp,
    input wire logic i_axi_arvalid,
    input wire logic o_axi_arready,
    input wire logic o_axi_rvalid,
    input wire logic i_axi_rready,
    // Status
    input wire logic o_irq,
    input wire logic o_acquiring
);
    logic wr_hs;
    logic mask_done;

    assign wr_hs = i_axi_awvalid && o_axi_awready && i_axi_wvalid
                   && o_axi_wready && i_axi_wstrb[0];

    // Mirror of the done-flag mask, taken at the bus handshake
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mask_done <= 1'b0;
        end else if (wr_hs && i_axi_awaddr == MASK_OFFSET) begin
            mask_done <= i_axi_wdata[FLAG_DONE];
        end
    end

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    property p_reset_idle;
        $rose(i_rst_n) |-> !o_acquiring && !o_irq && !o_axi_bvalid;
    endproperty
    property p_b_answer;
        wr_hs |-> ##2 o_axi_bvalid;
    endproperty
    property p_aw_back;
        o_axi_bvalid && i_axi_bready |=> o_axi_awready && o_axi_wready;
    endproperty
    property p_unmapped;
        wr_hs && i_axi_awaddr > DATA_OFFSET |-> ##2 o_axi_bresp == RESP_SLVERR;
    endproperty
    property p_r_answer;
        i_axi_arvalid && o_axi_arready |=> o_axi_rvalid && !o_axi_arready;
    endproperty
    property p_ar_back;
        o_axi_rvalid && i_axi_rready |=> o_axi_arready;
    endproperty
    property p_start;
        wr_hs && i_axi_awaddr == CTRL_OFFSET && !o_acquiring
        && i_axi_wdata[CTRL_START_BIT] |-> ##[2:4] o_acquiring;
    endproperty
    property p_done_irq;
        $fell(o_acquiring) && mask_done |-> o_irq;
    endproperty
    property p_irq_clear;
        wr_hs && i_axi_awaddr == STATUS_OFFSET && !o_acquiring
        && i_axi_wdata[1:0] == 2'h3 |-> ##3 !o_irq;
    endproperty
    property p_mask_off;
        wr_hs && i_axi_awaddr == MASK_OFFSET
        && i_axi_wdata[1:0] == 2'h0 |-> ##3 !o_irq;
    endproperty

    a_reset_idle: assert property (p_reset_idle) else $error("not idle");
    a_b_answer: assert property (p_b_answer) else $error("no bvalid");
    a_aw_back: assert property (p_aw_back) else $error("awready late");
    a_unmapped: assert property (p_unmapped) else $error("no slverr");
    a_r_answer: assert property (p_r_answer) else $error("no rvalid");
    a_ar_back: assert property (p_ar_back) else $error("arready late");
    a_start: assert property (p_start) else $error("no start");
    a_done_irq: assert property (p_done_irq) else $error("no irq");
    a_irq_clear: assert property (p_irq_clear) else $error("irq stuck");
    a_mask_off: assert property (p_mask_off) else $error("irq unmasked");

    c_start: cover property ($rose(o_acquiring));
    c_stop: cover property ($fell(o_acquiring));
    c_irq: cover property ($rose(o_irq));
    c_err: cover property (o_axi_bvalid && o_axi_bresp == RESP_SLVERR);
endmodule

bind acq_fifo_ctrl acq_fifo_ctrl_checker u_checker (.*);

// ==== sim/test_acq_fifo_ctrl.sv ====
// Self-checking bench for the acquisition control block
`timescale 1ns/1ns
module test_acq_fifo_ctrl
    import acq_pkg::*;
;
    //----------------------------------------------------------
    // Signals
    //----------------------------------------------------------
    logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, acq, s_valid, src_en;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [15:0] s_data;
    logic [3:0] src_period;
    int mismatches = 0;
    int tests_run = 0;
    logic [31:0] rst_val [5] = '{32'h0000_0000, 32'h0000_0100,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

    sample_source u_src (.i_ref_clk(clk), .i_rst_n(rst_n), .i_en(src_en),
        .i_period(src_period), .o_valid(s_valid), .o_data(s_data));

    acq_fifo_ctrl DUT (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_sample_valid(s_valid), .i_sample_data(s_data),
        .i_axi_awvalid(awvalid), .o_axi_awready(awready),
        .i_axi_awaddr(awaddr), .i_axi_awprot(3'h0),
        .i_axi_wvalid(wvalid), .o_axi_wready(wready),
        .i_axi_wdata(wdata), .i_axi_wstrb(4'hF),
        .o_axi_bvalid(bvalid), .i_axi_bready(bready), .o_axi_bresp(bresp),
        .i_axi_arvalid(arvalid), .o_axi_arready(arready),
        .i_axi_araddr(araddr), .i_axi_arprot(3'h0),
        .o_axi_rvalid(rvalid), .i_axi_rready(rready),
        .o_axi_rdata(rdata), .o_axi_rresp(rresp),
        .o_irq(irq), .o_acquiring(acq));

    //----------------------------------------------------------
    // Tasks
    //----------------------------------------------------------
    task automatic give_verdict;
        if (mismatches == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        rready <= 1'b0;
        chk("rresp", 32'(er), 32'(rresp));
    endtask

    task automatic rc(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        chk(nm, e, v);
    endtask

    //----------------------------------------------------------
    // Tests
    //----------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        give_verdict();
    end

    initial begin
        logic [31:0] v;
        logic [15:0] ex;
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, src_en, src_period} = 53'h1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) rc("reset", 8'(4 * i), rst_val[i]);
        wr(8'h18, 32'h0000_0001, RESP_SLVERR);
        rd(8'h18, v, RESP_SLVERR);
        chk("unmapped", 32'h0000_0000, v);
        wr(CTRL_OFFSET, 32'h0000_0001);
        rc("mode", CTRL_OFFSET, 32'h0000_0001);
        wr(CTRL_OFFSET, 32'h0000_0000);
        wr(LEN_OFFSET, 32'h0000_0000);
        rc("len_lo", LEN_OFFSET, 32'h0000_0001);
        wr(LEN_OFFSET, 32'h0000_0300);
        rc("len_hi", LEN_OFFSET, 32'h0000_0100);
        wr(LEN_OFFSET, 32'h0000_0004);
        // Single block, with more samples offered than the block holds
        wr(CTRL_OFFSET, 32'h0000_0002);
        src_en <= 1'b1;
        repeat (20) @(posedge clk);
        src_en <= 1'b0;
        rc("single", STATE_OFFSET, 32'h0004_0000);
        rc("done", STATUS_OFFSET, 32'h0000_0001);
        chk("irq_masked", 32'h0, 32'(irq));
        wr(MASK_OFFSET, 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk("irq_on", 32'h1, 32'(irq));
        wr(STATUS_OFFSET, 32'h0000_0003);
        repeat (3) @(posedge clk);
        chk("irq_clr", 32'h0, 32'(irq));
        for (int i = 1; i <= 4; i++) rc("data", DATA_OFFSET, 32'(i));
        rc("empty", DATA_OFFSET, 32'h0000_0000);
        rc("drained", STATE_OFFSET, 32'h0000_0000);
        // Continuous capture, slow source, host keeping up
        wr(MASK_OFFSET, 32'h0000_0003);
        wr(LEN_OFFSET, 32'h0000_0008);
        wr(CTRL_OFFSET, 32'h0000_0003);
        src_period <= 4'h8;
        src_en <= 1'b1;
        repeat (100) @(posedge clk);
        rc("block", STATUS_OFFSET, 32'h0000_0002);
        chk("irq_block", 32'h1, 32'(irq));
        ex = 16'h0001;
        for (int i = 0; i < 40; i++) begin
            rd(DATA_OFFSET, v);
            if (v !== 32'h0000_0000) begin
                chk("stream", 32'(ex), v);
                ex++;
            end
        end
        rd(STATE_OFFSET, v);
        chk("running", 32'h1, 32'(v[0]));
        rc("not_full", STATUS_OFFSET, 32'h0000_0002);
        wr(MASK_OFFSET, 32'h0000_0001);
        // Host stops reading, source at full rate
        src_period <= 4'h1;
        repeat (300) @(posedge clk);
        rc("full", STATE_OFFSET, 32'h0100_0000);
        rc("full_flag", STATUS_OFFSET, 32'h0000_0003);
        chk("acq_off", 32'h0, 32'(acq));
        rc("order", DATA_OFFSET, 32'(ex));
        rc("freed", STATE_OFFSET, 32'h00FF_0000);
        src_en <= 1'b0;
        wr(MASK_OFFSET, 32'h0000_0000);
        repeat (3) @(posedge clk);
        chk("irq_mask", 32'h0, 32'(irq));
        give_verdict();
    end
endmodule
